// ---- verilog/conn_pkg.sv ----
/*
  Package for the connection-instance block: register map, field layouts,
  state and kind codes, identifier limits and defaults.
  Assumes an APB master with 32-bit data and one aligned word per register.
*/
package conn_pkg;

  localparam logic [7:0] OFF_STATE = 8'h00;
  localparam logic [7:0] OFF_KIND = 8'h04;
  localparam logic [7:0] OFF_TRIG = 8'h08;
  localparam logic [7:0] OFF_TX_ID = 8'h0C;
  localparam logic [7:0] OFF_RX_ID = 8'h10;
  localparam logic [7:0] OFF_GROUP = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_TX_FRAME = 8'h24;

  typedef enum logic [7:0] {
    ST_NONE = 8'h00,
    ST_CONFIG = 8'h01,
    ST_WAIT_ID = 8'h02,
    ST_ESTAB = 8'h03,
    ST_TIMEOUT = 8'h04
  } conn_state_t;

  localparam logic [7:0] KIND_EXPLICIT = 8'h00;
  localparam logic [7:0] KIND_IO = 8'h01;

  localparam logic [15:0] ID_MAX = 16'h07F0;
  localparam logic [15:0] ID_DEFAULT = 16'hFFFF;
  localparam logic [7:0] TRIG_RESET = 8'h00;
  localparam logic [7:0] GROUP_RESET = 8'hFF;
  localparam logic [3:0] GROUP_MAX = 4'h3;
  localparam logic [3:0] GROUP_DEFAULT = 4'hF;

  localparam int TRIG_PROD_BIT = 0;
  localparam int TRIG_CONS_BIT = 1;

  // Command register bits
  localparam int CMD_CREATE = 0;
  localparam int CMD_CREATE_DYN = 1;
  localparam int CMD_APPLY = 2;
  localparam int CMD_DELETE = 3;
  localparam int CMD_SEND = 4;

  // Interrupt status bits
  localparam int EV_ESTAB = 0;
  localparam int EV_WAIT_ID = 1;
  localparam int EV_TIMEOUT = 2;
  localparam int EV_RX = 3;
  localparam int EV_FREED = 4;
  localparam int EV_REFUSED = 5;
  localparam int EV_W = 6;

  localparam logic [31:0] TIMEOUT_DEFAULT = 32'h0000_1000;

  typedef struct packed {
    logic valid;
    logic [10:0] ident;
  } can_frame_t;

endpackage : conn_pkg

// ---- verilog/conn_instance.sv ----
/*
  One connection instance of a CAN-based fieldbus node, with APB registers,
  identifier match on receive, identifier insertion on transmit, inactivity
  timer and a level interrupt.
  Assumes all inputs are synchronous to i_sys_clk and that the CAN
  controller accepts a one-cycle transmit request.
*/
// Overview of operation
// RQ1: State code 0 none, 1 config, 2 wait id, 3 established, 4 timed-out.
// RQ2: Created instance stays in configuring until configured and told to apply.
// RQ3: Apply without a generated identifier goes to waiting-for-identifier.
// RQ4: Established is reached only after configuration has been applied.
// RQ5: Inactivity timer expiry moves the instance to timed-out.
// RQ6: Dynamic instance is freed if its explicit link breaks before established.
// RQ7: Entering established starts all timers of the instance.
// RQ8: Kind is 0 explicit, 1 I/O; other values reserved.
// RQ9: Eight-bit role-and-trigger byte marks producing, consuming or both.
// RQ10: Transmit frames carry the transmit identifier, range 0 to 7F0.
// RQ11: Transmit identifier defaults to FFFF for I/O and stays so when consumer only.
// RQ12: Receive frames accepted only when identifier equals receive identifier.
// RQ13: Receive identifier defaults to FFFF for I/O and stays so when producer only.
// RQ14: Message-group byte holds production and consumption halves.
// RQ15: Attributes take their defaults unless otherwise dictated.
// RQ16: Upper half selects production group 0 to 3, F default.
// RQ17: Lower half selects consumption group 0 to 3, F default.
// RQ18: Reserved codes written to state, kind or identifiers are refused.
`timescale 1ns/1ns
module conn_instance #(
  parameter logic [31:0] TIMEOUT_CYCLES = conn_pkg::TIMEOUT_DEFAULT
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire conn_pkg::can_frame_t i_rx_frame,
  input wire logic i_explicit_link_up,
  output conn_pkg::can_frame_t o_tx_frame,
  output logic o_rx_accept,
  output logic o_irq
);

  // A zero count would never time out: expiry is taken at a count of one and the timer stops at zero
  if (TIMEOUT_CYCLES == 32'h0000_0000) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES must be nonzero");
  end

  conn_pkg::conn_state_t state_q;
  logic [7:0] kind_q;
  logic [7:0] trig_q;
  logic [15:0] tx_id_q;
  logic [15:0] rx_id_q;
  logic [7:0] group_q;
  logic dyn_q;
  logic [31:0] timer_q;
  logic [conn_pkg::EV_W-1:0] stat_q;
  logic [conn_pkg::EV_W-1:0] mask_q;
  logic [conn_pkg::EV_W-1:0] ev;
  logic [conn_pkg::EV_W-1:0] stat_d;

  logic wr;
  logic rd;
  logic cmd_wr;
  logic produces;
  logic consumes;
  logic id_ok;
  logic ids_ready;
  logic apply_ok;
  logic timer_expired;
  logic link_broken;
  logic rx_hit;
  logic refused;

  assign wr = i_ce && psel && penable && pwrite;
  assign rd = i_ce && psel && penable && !pwrite;
  assign cmd_wr = wr && (paddr == conn_pkg::OFF_CMD);
  assign pready = 1'b1;
  assign produces = trig_q[conn_pkg::TRIG_PROD_BIT]; // RQ9
  assign consumes = trig_q[conn_pkg::TRIG_CONS_BIT]; // RQ9
  assign id_ok = (pwdata[15:0] <= conn_pkg::ID_MAX) || (pwdata[15:0] == conn_pkg::ID_DEFAULT);

  // Both used identifiers must be valid before the link can run
  assign ids_ready = (!produces || tx_id_q <= conn_pkg::ID_MAX)
                  && (!consumes || rx_id_q <= conn_pkg::ID_MAX);
  assign apply_ok = cmd_wr && pwdata[conn_pkg::CMD_APPLY] && state_q == conn_pkg::ST_CONFIG;
  assign timer_expired = state_q == conn_pkg::ST_ESTAB && timer_q == 32'h0000_0001;
  assign link_broken = dyn_q && !i_explicit_link_up
                    && (state_q == conn_pkg::ST_CONFIG || state_q == conn_pkg::ST_WAIT_ID);
  assign rx_hit = i_rx_frame.valid && state_q == conn_pkg::ST_ESTAB && consumes
               && {5'h00, i_rx_frame.ident} == rx_id_q; // RQ12

  // Attribute writes are legal only while the instance exists
  logic attr_wr;
  assign attr_wr = wr && state_q != conn_pkg::ST_NONE;

  // Lifecycle state
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= conn_pkg::ST_NONE; // RQ1
      dyn_q <= 1'b0;
    end else if (i_ce) begin
      if (link_broken) begin
        state_q <= conn_pkg::ST_NONE; // RQ6
        dyn_q <= 1'b0;
      end else if (cmd_wr && pwdata[conn_pkg::CMD_DELETE]) begin
        state_q <= conn_pkg::ST_NONE;
        dyn_q <= 1'b0;
      end else if (cmd_wr && state_q == conn_pkg::ST_NONE
                   && (pwdata[conn_pkg::CMD_CREATE] || pwdata[conn_pkg::CMD_CREATE_DYN])) begin
        state_q <= conn_pkg::ST_CONFIG; // RQ2
        dyn_q <= pwdata[conn_pkg::CMD_CREATE_DYN];
      end else if (apply_ok) begin
        state_q <= ids_ready ? conn_pkg::ST_ESTAB : conn_pkg::ST_WAIT_ID; // RQ3 RQ4
      end else if (state_q == conn_pkg::ST_WAIT_ID && ids_ready) begin
        state_q <= conn_pkg::ST_ESTAB; // RQ4
      end else if (timer_expired) begin
        state_q <= conn_pkg::ST_TIMEOUT; // RQ5
      end
    end
  end

  // Attributes; reserved values are refused and leave the field alone
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      kind_q <= conn_pkg::KIND_IO;
      trig_q <= conn_pkg::TRIG_RESET;
      tx_id_q <= conn_pkg::ID_DEFAULT; // RQ11 RQ15
      rx_id_q <= conn_pkg::ID_DEFAULT; // RQ13 RQ15
      group_q <= conn_pkg::GROUP_RESET; // RQ16 RQ17
    end else if (i_ce) begin
      if (cmd_wr && state_q == conn_pkg::ST_NONE
          && (pwdata[conn_pkg::CMD_CREATE] || pwdata[conn_pkg::CMD_CREATE_DYN])) begin
        kind_q <= conn_pkg::KIND_IO;
        trig_q <= conn_pkg::TRIG_RESET;
        tx_id_q <= conn_pkg::ID_DEFAULT; // RQ15
        rx_id_q <= conn_pkg::ID_DEFAULT;
        group_q <= conn_pkg::GROUP_RESET;
      end else if (attr_wr && state_q == conn_pkg::ST_CONFIG) begin
        // An I/O instance holds the default identifier on any unused direction
        if (paddr == conn_pkg::OFF_KIND && pwdata[7:1] == 7'h00) begin
          kind_q <= pwdata[7:0]; // RQ8 RQ18
          if (pwdata[7:0] == conn_pkg::KIND_IO && !produces) begin
            tx_id_q <= conn_pkg::ID_DEFAULT; // RQ11
          end
          if (pwdata[7:0] == conn_pkg::KIND_IO && !consumes) begin
            rx_id_q <= conn_pkg::ID_DEFAULT; // RQ13
          end
        end
        if (paddr == conn_pkg::OFF_TRIG) begin
          trig_q <= pwdata[7:0]; // RQ9
          if (kind_q == conn_pkg::KIND_IO && !pwdata[conn_pkg::TRIG_PROD_BIT]) begin
            tx_id_q <= conn_pkg::ID_DEFAULT; // RQ11
          end
          if (kind_q == conn_pkg::KIND_IO && !pwdata[conn_pkg::TRIG_CONS_BIT]) begin
            rx_id_q <= conn_pkg::ID_DEFAULT; // RQ13
          end
        end
        if (paddr == conn_pkg::OFF_GROUP) begin
          group_q <= pwdata[7:0]; // RQ14
        end
      end
      // Identifiers may also be set while waiting for them
      if (attr_wr && (state_q == conn_pkg::ST_CONFIG || state_q == conn_pkg::ST_WAIT_ID)) begin
        if (paddr == conn_pkg::OFF_TX_ID && id_ok) begin
          // A consumer-only I/O instance keeps the default
          if (produces || kind_q != conn_pkg::KIND_IO) begin
            tx_id_q <= pwdata[15:0]; // RQ11 RQ18
          end
        end
        if (paddr == conn_pkg::OFF_RX_ID && id_ok) begin
          if (consumes || kind_q != conn_pkg::KIND_IO) begin
            rx_id_q <= pwdata[15:0]; // RQ13 RQ18
          end
        end
      end
    end
  end

  // Refused writes: reserved kind or identifier, or write to state
  always_comb begin
    refused = 1'b0;
    if (wr) begin
      unique case (paddr)
        conn_pkg::OFF_STATE: refused = 1'b1; // RQ18
        conn_pkg::OFF_KIND: refused = pwdata[7:1] != 7'h00; // RQ18
        conn_pkg::OFF_TX_ID: refused = !id_ok;
        conn_pkg::OFF_RX_ID: refused = !id_ok;
        conn_pkg::OFF_GROUP: refused = 1'b0;
        default: refused = 1'b0;
      endcase
    end
  end

  // Inactivity timer, armed on entry to established and rearmed by each accepted receive frame
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      timer_q <= TIMEOUT_CYCLES;
    end else if (i_ce) begin
      if (state_q != conn_pkg::ST_ESTAB) begin
        timer_q <= TIMEOUT_CYCLES; // RQ7
      end else if (rx_hit) begin
        timer_q <= TIMEOUT_CYCLES;
      end else if (timer_q != 32'h0000_0000) begin
        timer_q <= timer_q - 32'h0000_0001;
      end
    end
  end

  // Transmit request carries the transmit identifier
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_tx_frame <= '0;
      o_rx_accept <= 1'b0;
    end else if (i_ce) begin
      o_tx_frame.valid <= cmd_wr && pwdata[conn_pkg::CMD_SEND]
                       && state_q == conn_pkg::ST_ESTAB && produces;
      o_tx_frame.ident <= tx_id_q[10:0]; // RQ10
      o_rx_accept <= rx_hit; // RQ12
    end
  end

  // Events; set wins over the read clear
  assign ev[conn_pkg::EV_ESTAB] = state_q != conn_pkg::ST_ESTAB
                               && (apply_ok ? ids_ready
                                  : (state_q == conn_pkg::ST_WAIT_ID && ids_ready))
                               && !link_broken;
  assign ev[conn_pkg::EV_WAIT_ID] = apply_ok && !ids_ready && !link_broken;
  assign ev[conn_pkg::EV_TIMEOUT] = timer_expired;
  assign ev[conn_pkg::EV_RX] = rx_hit;
  assign ev[conn_pkg::EV_FREED] = link_broken;
  assign ev[conn_pkg::EV_REFUSED] = refused;

  always_comb begin
    stat_d = stat_q;
    if (rd && paddr == conn_pkg::OFF_IRQ_STAT) begin
      stat_d = '0;
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stat_q <= '0;
      mask_q <= '0;
    end else if (i_ce) begin
      stat_q <= stat_d;
      if (wr && paddr == conn_pkg::OFF_IRQ_MASK) begin
        mask_q <= pwdata[conn_pkg::EV_W-1:0];
      end
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // Read data
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      conn_pkg::OFF_STATE: prdata = {24'h000000, state_q};
      conn_pkg::OFF_KIND: prdata = {24'h000000, kind_q};
      conn_pkg::OFF_TRIG: prdata = {24'h000000, trig_q};
      conn_pkg::OFF_TX_ID: prdata = {16'h0000, tx_id_q};
      conn_pkg::OFF_RX_ID: prdata = {16'h0000, rx_id_q};
      conn_pkg::OFF_GROUP: prdata = {24'h000000, group_q};
      conn_pkg::OFF_CMD: prdata = 32'h0000_0000;
      conn_pkg::OFF_IRQ_STAT: prdata = {26'h0000000, stat_q};
      conn_pkg::OFF_IRQ_MASK: prdata = {26'h0000000, mask_q};
      conn_pkg::OFF_TX_FRAME: prdata = {21'h000000, o_tx_frame.ident};
      default: pslverr = psel && penable;
    endcase
  end

  sequence s_apply_ready;
    apply_ok && ids_ready && !link_broken;
  endsequence

  chk_apply_estab: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ4
    s_apply_ready |=> state_q == conn_pkg::ST_ESTAB)
    else $error("apply with ids did not establish");

  chk_apply_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ3
    (apply_ok && !ids_ready && !link_broken) |=> state_q == conn_pkg::ST_WAIT_ID)
    else $error("apply without ids did not wait");

  chk_state_legal: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ1
    state_q <= conn_pkg::ST_TIMEOUT)
    else $error("state code reserved");

  chk_estab_from: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ4
    (state_q == conn_pkg::ST_ESTAB && $past(state_q) != conn_pkg::ST_ESTAB)
      |-> ($past(state_q) == conn_pkg::ST_CONFIG || $past(state_q) == conn_pkg::ST_WAIT_ID))
    else $error("established entered from wrong state");

  chk_timer_arm: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ7
    (i_ce && state_q != conn_pkg::ST_ESTAB) |=> timer_q == TIMEOUT_CYCLES)
    else $error("timer not armed");

  chk_timeout_go: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ5
    (i_ce && timer_expired && !link_broken && !cmd_wr) |=> state_q == conn_pkg::ST_TIMEOUT)
    else $error("timeout not taken");

  chk_link_free: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ6
    (i_ce && link_broken) |=> state_q == conn_pkg::ST_NONE && stat_q[conn_pkg::EV_FREED])
    else $error("dynamic instance not freed");

  chk_kind_legal: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ8
    kind_q[7:1] == 7'h00)
    else $error("kind reserved");

  chk_id_range: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ18
    (tx_id_q <= conn_pkg::ID_MAX || tx_id_q == conn_pkg::ID_DEFAULT)
      && (rx_id_q <= conn_pkg::ID_MAX || rx_id_q == conn_pkg::ID_DEFAULT))
    else $error("identifier reserved");

  chk_tx_ident: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ10
    o_tx_frame.valid |-> {5'h00, o_tx_frame.ident} == $past(tx_id_q))
    else $error("tx identifier mismatch");

  chk_rx_match: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ12
    o_rx_accept |-> {5'h00, $past(i_rx_frame.ident)} == $past(rx_id_q))
    else $error("rx accepted wrong identifier");

  chk_rx_ignore: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ12
    (i_ce && i_rx_frame.valid && {5'h00, i_rx_frame.ident} != rx_id_q) |=> !o_rx_accept)
    else $error("rx accepted foreign identifier");

  chk_tx_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ10
    (cmd_wr && pwdata[conn_pkg::CMD_SEND] && state_q == conn_pkg::ST_ESTAB && produces)
      |=> o_tx_frame.valid)
    else $error("send did not transmit");

  chk_tx_default: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ11
    (kind_q == conn_pkg::KIND_IO && !produces) |-> tx_id_q == conn_pkg::ID_DEFAULT)
    else $error("transmit identifier not at default");

  chk_rx_default: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ13
    (kind_q == conn_pkg::KIND_IO && !consumes) |-> rx_id_q == conn_pkg::ID_DEFAULT)
    else $error("receive identifier not at default");

  chk_refuse_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ18
    (i_ce && refused) |=> stat_q[conn_pkg::EV_REFUSED])
    else $error("refused write not flagged");

  chk_refuse_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ18
    (wr && paddr == conn_pkg::OFF_KIND && pwdata[7:1] != 7'h00) |=> $stable(kind_q))
    else $error("reserved kind stored");

  sequence s_enter_estab;
    state_q != conn_pkg::ST_ESTAB ##1 state_q == conn_pkg::ST_ESTAB;
  endsequence

  chk_estab_timer: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ7
    s_enter_estab |-> timer_q == TIMEOUT_CYCLES)
    else $error("timer not started on establish");

  chk_timeout_stay: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ5
    (state_q == conn_pkg::ST_TIMEOUT && !(cmd_wr && pwdata[conn_pkg::CMD_DELETE]))
      |=> state_q == conn_pkg::ST_TIMEOUT)
    else $error("timed-out state left without delete");

  chk_group_write: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ14
    (attr_wr && state_q == conn_pkg::ST_CONFIG && paddr == conn_pkg::OFF_GROUP)
      |=> group_q == $past(pwdata[7:0]))
    else $error("group byte not stored");

  chk_wait_leave: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ4
    (i_ce && state_q == conn_pkg::ST_WAIT_ID && ids_ready && !link_broken
      && !(cmd_wr && pwdata[conn_pkg::CMD_DELETE])) |=> state_q == conn_pkg::ST_ESTAB)
    else $error("waiting instance not established");

  chk_create_config: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RQ2
    (cmd_wr && state_q == conn_pkg::ST_NONE && pwdata[conn_pkg::CMD_CREATE]
      && !pwdata[conn_pkg::CMD_DELETE]) |=> state_q == conn_pkg::ST_CONFIG)
    else $error("create did not enter configuring");

endmodule : conn_instance

// ---- dv/can_peer.sv ----
/*
  Model of the other nodes on the bus: sends frames to the instance and
  records the frames that the instance transmits.
  Assumes frames are one-cycle strobes synchronous to the node clock.
*/
`timescale 1ns/1ns
module can_peer (
  input wire logic i_sys_clk,
  input wire conn_pkg::can_frame_t i_tx_frame,
  output conn_pkg::can_frame_t o_rx_frame
);
  int tx_count = 0;
  logic [10:0] last_tx = 11'h000;

  initial o_rx_frame = '0;

  // After the strobe the identifier lines show junk, so a stale match cannot pass
  task automatic send(input logic [10:0] id);
    o_rx_frame <= '{valid: 1'b1, ident: id};
    @(posedge i_sys_clk);
    o_rx_frame <= '{valid: 1'b0, ident: ~id};
  endtask : send

  always @(posedge i_sys_clk) begin
    if (i_tx_frame.valid === 1'b1) begin
      tx_count <= tx_count + 1;
      last_tx <= i_tx_frame.ident;
    end
  end
endmodule : can_peer

// ---- dv/tb_top.sv ----
/*
  Self-checking bench for one connection instance: APB master tasks,
  one task per scenario, frames exchanged through the peer model.
  Assumes zero or more wait states on APB and a shortened inactivity timer.
*/
`timescale 1ns/1ns
module tb_top;
  // Short timer keeps the expiry scenario brief
  localparam logic [31:0] TMO = 32'h0000_0040;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic o_rx_accept;
  logic o_irq;
  logic i_explicit_link_up = 1'b1;
  logic i_ce = 1'b1;
  conn_pkg::can_frame_t rx_frame;
  conn_pkg::can_frame_t tx_frame;
  int num_errors = 0;
  int check_count = 0;

  always #20 i_sys_clk = ~i_sys_clk;

  conn_instance #(.TIMEOUT_CYCLES(TMO)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_ce(i_ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_rx_frame(rx_frame), .i_explicit_link_up(i_explicit_link_up),
    .o_tx_frame(tx_frame), .o_rx_accept(o_rx_accept), .o_irq(o_irq));

  can_peer peer (.i_sys_clk(i_sys_clk), .i_tx_frame(tx_frame), .o_rx_frame(rx_frame));

  task automatic results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] x, input logic [31:0] got);
    check_count++;
    if (got !== x) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, x, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, {31'h0, pready});
      results();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg %h", a), x, r);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic cmd(input int b);
    wr(conn_pkg::OFF_CMD, 32'h1 << b);
  endtask : cmd

  task automatic irq(input logic x);
    chk("irq", {31'h0, x}, {31'h0, o_irq});
  endtask : irq

  task automatic hit(input logic [10:0] id, input logic x);
    logic seen;
    seen = 1'b0;
    peer.send(id);
    repeat (2) begin
      @(posedge i_sys_clk);
      seen = seen | o_rx_accept;
    end
    chk("rx accept", {31'h0, x}, {31'h0, seen});
  endtask : hit

  task automatic do_reset;
    i_rst <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
  endtask : do_reset

  task automatic s_reset_values;
    logic [31:0] r;
    logic e;
    do_reset();
    rd(conn_pkg::OFF_STATE, 32'h0);
    rd(conn_pkg::OFF_KIND, 32'h1);
    rd(conn_pkg::OFF_TRIG, 32'h0);
    rd(conn_pkg::OFF_TX_ID, 32'hFFFF);
    rd(conn_pkg::OFF_RX_ID, 32'hFFFF);
    rd(conn_pkg::OFF_GROUP, 32'hFF);
    wr(conn_pkg::OFF_STATE, 32'h3);
    rd(conn_pkg::OFF_STATE, 32'h0);
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk("pslverr", 32'h1, {31'h0, e});
  endtask : s_reset_values

  task automatic s_establish;
    do_reset();
    cmd(conn_pkg::CMD_CREATE);
    rd(conn_pkg::OFF_STATE, 32'h1);
    wr(conn_pkg::OFF_KIND, 32'h2);
    rd(conn_pkg::OFF_KIND, 32'h1);
    wr(conn_pkg::OFF_KIND, 32'h0);
    rd(conn_pkg::OFF_KIND, 32'h0);
    wr(conn_pkg::OFF_KIND, 32'h1);
    wr(conn_pkg::OFF_TX_ID, 32'h7F1);
    rd(conn_pkg::OFF_TX_ID, 32'hFFFF);
    wr(conn_pkg::OFF_RX_ID, 32'hFFFE);
    rd(conn_pkg::OFF_RX_ID, 32'hFFFF);
    rd(conn_pkg::OFF_IRQ_STAT, 32'h1 << conn_pkg::EV_REFUSED);
    // Role first: an I/O instance holds unused identifiers at the default
    wr(conn_pkg::OFF_TRIG, 32'h3);
    wr(conn_pkg::OFF_TX_ID, 32'h7F0);
    wr(conn_pkg::OFF_RX_ID, 32'h123);
    wr(conn_pkg::OFF_GROUP, 32'h30);
    rd(conn_pkg::OFF_GROUP, 32'h30);
    wr(conn_pkg::OFF_IRQ_MASK, 32'h1 << conn_pkg::EV_ESTAB);
    rd(conn_pkg::OFF_STATE, 32'h1);
    irq(1'b0);
    cmd(conn_pkg::CMD_APPLY);
    rd(conn_pkg::OFF_STATE, 32'h3);
    irq(1'b1);
    rd(conn_pkg::OFF_IRQ_STAT, 32'h1 << conn_pkg::EV_ESTAB);
    irq(1'b0);
    hit(11'h124, 1'b0);
    hit(11'h123, 1'b1);
    cmd(conn_pkg::CMD_SEND);
    repeat (2) @(posedge i_sys_clk);
    chk("tx count", 32'h1, peer.tx_count);
    chk("tx ident", 32'h7F0, {21'h0, peer.last_tx});
    rd(conn_pkg::OFF_TX_FRAME, 32'h7F0);
    rd(conn_pkg::OFF_IRQ_STAT, 32'h1 << conn_pkg::EV_RX);
    // Last hit reloaded the timer, so the instance must still be up here
    repeat (40) @(posedge i_sys_clk);
    rd(conn_pkg::OFF_STATE, 32'h3);
    repeat (20) @(posedge i_sys_clk);
    rd(conn_pkg::OFF_STATE, 32'h4);
    rd(conn_pkg::OFF_IRQ_STAT, 32'h1 << conn_pkg::EV_TIMEOUT);
  endtask : s_establish

  task automatic s_wait_id;
    do_reset();
    cmd(conn_pkg::CMD_CREATE);
    wr(conn_pkg::OFF_TRIG, 32'h3);
    wr(conn_pkg::OFF_TX_ID, 32'h10);
    cmd(conn_pkg::CMD_APPLY);
    rd(conn_pkg::OFF_STATE, 32'h2);
    rd(conn_pkg::OFF_TX_ID, 32'h10);
    rd(conn_pkg::OFF_IRQ_STAT, 32'h1 << conn_pkg::EV_WAIT_ID);
    wr(conn_pkg::OFF_RX_ID, 32'h20);
    rd(conn_pkg::OFF_STATE, 32'h3);
  endtask : s_wait_id

  task automatic s_dynamic;
    do_reset();
    cmd(conn_pkg::CMD_CREATE_DYN);
    rd(conn_pkg::OFF_STATE, 32'h1);
    i_explicit_link_up <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    rd(conn_pkg::OFF_STATE, 32'h0);
    irq(1'b0);
    rd(conn_pkg::OFF_IRQ_STAT, 32'h1 << conn_pkg::EV_FREED);
    i_explicit_link_up <= 1'b1;
  endtask : s_dynamic

  task automatic s_one_way;
    do_reset();
    cmd(conn_pkg::CMD_CREATE);
    wr(conn_pkg::OFF_TRIG, 32'h2);
    wr(conn_pkg::OFF_TX_ID, 32'h55);
    rd(conn_pkg::OFF_TX_ID, 32'hFFFF);
    wr(conn_pkg::OFF_TRIG, 32'h1);
    wr(conn_pkg::OFF_RX_ID, 32'h66);
    rd(conn_pkg::OFF_RX_ID, 32'hFFFF);
    wr(conn_pkg::OFF_TX_ID, 32'h55);
    rd(conn_pkg::OFF_TX_ID, 32'h55);
    wr(conn_pkg::OFF_TRIG, 32'h2);
    rd(conn_pkg::OFF_TX_ID, 32'hFFFF);
    // Clock enable low: the write completes on the bus but must change nothing
    i_ce <= 1'b0;
    wr(conn_pkg::OFF_TRIG, 32'h1);
    i_ce <= 1'b1;
    rd(conn_pkg::OFF_TRIG, 32'h2);
    cmd(conn_pkg::CMD_DELETE);
    rd(conn_pkg::OFF_STATE, 32'h0);
  endtask : s_one_way

  initial begin
    s_reset_values();
    s_establish();
    s_wait_id();
    s_dynamic();
    s_one_way();
    results();
  end
endmodule : tb_top
